// [rtl/acv_host.sv]
`timescale 1ns/100ps
`default_nettype none
module acv_host
    import acv_pkg::*;
#(
    parameter int SETTLE_CYC = REF_SETTLE_CYC,
    parameter int WARP_LIMIT = WARP_MAX_CYC,
    parameter bit TIE_CS = 1'b0
) (
    input wire logic clk,
    input wire logic rst_b,
    acv_link_if.host link,
    input wire logic start,
    input wire logic [3:0] n_words,
    input wire logic [15:0] cfg_word,
    input wire logic warp_mode,
    input wire logic sleep_req,
    output logic ready,
    output logic interval_late,
    output logic out_valid,
    input wire logic out_ready,
    output logic [15:0] out_data
);
    typedef enum logic [2:0] {HS_IDLE, HS_CNV, HS_WAIT, HS_XFER, HS_SLEEP, HS_RST, HS_SETTLE} acv_hstate_t;

    acv_hstate_t st_r, st_nxt;
    logic b1_r, b2_r, sd1_r, sd2_r;
    logic [23:0] cnt_r, cnt_nxt;
    logic [23:0] gap_r, gap_nxt;
    logic sck_r, sck_nxt, cnv_r, cnv_nxt, din_r, din_nxt;
    logic [15:0] cfg_sh_r, cfg_sh_nxt, rx_r, rx_nxt;
    logic [3:0] bit_r, bit_nxt, word_r, word_nxt;
    logic [4:0] cbits_r, cbits_nxt;
    logic seen_r, seen_nxt, dummy_r, dummy_nxt, late_r, late_nxt, push_r, push_nxt;
    logic in_ready;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            b1_r <= 1'b0;
            b2_r <= 1'b0;
            sd1_r <= 1'b0;
            sd2_r <= 1'b0;
        end else begin
            b1_r <= link.busy_or_second_data_out;
            b2_r <= b1_r;
            sd1_r <= link.sdo;
            sd2_r <= sd1_r;
        end
    end

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        gap_nxt = (gap_r == 24'hFF_FFFF) ? gap_r : gap_r + 24'd1;
        sck_nxt = sck_r;
        cnv_nxt = cnv_r;
        din_nxt = din_r;
        cfg_sh_nxt = cfg_sh_r;
        rx_nxt = rx_r;
        bit_nxt = bit_r;
        word_nxt = word_r;
        cbits_nxt = cbits_r;
        seen_nxt = seen_r;
        dummy_nxt = dummy_r;
        late_nxt = late_r;
        // Push request holds until the buffer takes it
        push_nxt = push_r && !in_ready;
        case (st_r)
            HS_IDLE: begin
                if (sleep_req) begin
                    st_nxt = HS_SLEEP;
                end else if (start) begin
                    late_nxt = warp_mode && (gap_r > 24'(WARP_LIMIT));
                    gap_nxt = 24'd0;
                    cnv_nxt = 1'b1;
                    cnt_nxt = 24'(CNV_HIGH_CYC);
                    seen_nxt = 1'b0;
                    st_nxt = HS_CNV;
                end
            end
            HS_CNV: begin
                if (b2_r) begin
                    seen_nxt = 1'b1;
                end
                if (cnt_r == 24'd1) begin
                    cnv_nxt = 1'b0;
                    st_nxt = HS_WAIT;
                end else begin
                    cnt_nxt = cnt_r - 24'd1;
                end
            end
            HS_WAIT: begin
                // Serial lines still until busy falls
                if (b2_r) begin
                    seen_nxt = 1'b1;
                end else if (seen_r) begin
                    st_nxt = HS_XFER;
                    cfg_sh_nxt = {cfg_word[14:0], 1'b0};
                    din_nxt = cfg_word[15];
                    cbits_nxt = 5'd0;
                    bit_nxt = 4'd0;
                    word_nxt = 4'd0;
                    cnt_nxt = 24'(SCK_HALF_CYC);
                end
            end
            HS_XFER: begin
                // Back-pressure freezes the serial clock
                if (!(push_r || (!in_ready && bit_r == 4'd0 && word_r != 4'd0))) begin
                    if (cnt_r == 24'd1) begin
                        cnt_nxt = 24'(SCK_HALF_CYC);
                        sck_nxt = !sck_r;
                        if (!sck_r) begin
                            // Config goes out in first 16 clocks
                            if (cbits_r < 5'd16) begin
                                cbits_nxt = cbits_r + 5'd1;
                            end
                        end else begin
                            // Sampled at the fall: the synced line lags the far end by two clocks
                            rx_nxt = {rx_r[14:0], sd2_r};
                            bit_nxt = bit_r + 4'd1;
                            din_nxt = (cbits_r < 5'd16) ? cfg_sh_r[15] : 1'b0;
                            cfg_sh_nxt = {cfg_sh_r[14:0], 1'b0};
                            if (bit_r == 4'd15) begin
                                word_nxt = word_r + 4'd1;
                                push_nxt = !dummy_r;
                                if (word_r + 4'd1 == n_words) begin
                                    st_nxt = HS_IDLE;
                                    dummy_nxt = 1'b0;
                                end
                            end
                        end
                    end else begin
                        cnt_nxt = cnt_r - 24'd1;
                    end
                end
            end
            HS_SLEEP: begin
                if (!sleep_req) begin
                    cnt_nxt = 24'(RST_PULSE_CYC);
                    st_nxt = HS_RST;
                end
            end
            HS_RST: begin
                if (cnt_r == 24'd1) begin
                    cnt_nxt = 24'(SETTLE_CYC);
                    dummy_nxt = 1'b1;
                    st_nxt = HS_SETTLE;
                end else begin
                    cnt_nxt = cnt_r - 24'd1;
                end
            end
            default: begin
                if (cnt_r <= 24'd1) begin
                    st_nxt = HS_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 24'd1;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r <= HS_IDLE;
            cnt_r <= 24'd0;
            gap_r <= 24'd0;
            sck_r <= 1'b0;
            cnv_r <= 1'b0;
            din_r <= 1'b0;
            cfg_sh_r <= 16'h0000;
            rx_r <= 16'h0000;
            bit_r <= 4'd0;
            word_r <= 4'd0;
            cbits_r <= 5'd0;
            seen_r <= 1'b0;
            dummy_r <= 1'b0;
            late_r <= 1'b0;
            push_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            gap_r <= gap_nxt;
            sck_r <= sck_nxt;
            cnv_r <= cnv_nxt;
            din_r <= din_nxt;
            cfg_sh_r <= cfg_sh_nxt;
            rx_r <= rx_nxt;
            bit_r <= bit_nxt;
            word_r <= word_nxt;
            cbits_r <= cbits_nxt;
            seen_r <= seen_nxt;
            dummy_r <= dummy_nxt;
            late_r <= late_nxt;
            push_r <= push_nxt;
        end
    end

    acv_buf2 #(.W(16)) u_buf (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(push_r),
        .in_ready(in_ready),
        .in_data(rx_r),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data)
    );

    assign link.convert_strobe = cnv_r;
    // Chip select may follow the strobe
    assign link.cs_b = TIE_CS ? cnv_r : (st_r != HS_XFER);
    assign link.sck = sck_r;
    assign link.din = din_r;
    assign link.power_down_input = (st_r == HS_SLEEP);
    assign link.reset_pin = (st_r == HS_RST);
    assign ready = (st_r == HS_IDLE);
    assign interval_late = late_r;
endmodule
`default_nettype wire

// [include/acv_pkg.sv]
package acv_pkg;
    localparam int CFG_W = 16;
    localparam logic [15:0] CFG_DEFAULT = 16'hFFFF;
    localparam int CFG_UPD_BIT = 15;
    localparam int CFG_CH_LSB = 13;
    localparam int CFG_CH_W = 2;
    localparam int CFG_CMS_BIT = 1;
    localparam int CFG_REF_BIT = 2;
    localparam int MAX_CH = 8;
    localparam int CLK_NS = 10;
    localparam int TCONV_WARP_NS = 400;
    localparam int TCONV_NORM_NS = 500;
    localparam int TCONV_WARP_CYC = (TCONV_WARP_NS + CLK_NS - 1) / CLK_NS;
    localparam int TCONV_NORM_CYC = (TCONV_NORM_NS + CLK_NS - 1) / CLK_NS;
    localparam int SCK_HALF_CYC = 4;
    localparam int CNV_HIGH_CYC = 3;
    localparam int RST_PULSE_CYC = 4;
    localparam int REF_SETTLE_MS = 100;
    localparam int REF_SETTLE_CYC = REF_SETTLE_MS * (1000000 / CLK_NS);
    localparam int WARP_MAX_NS = 20000;
    localparam int WARP_MAX_CYC = WARP_MAX_NS / CLK_NS;
endpackage

// [include/acv_link_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface acv_link_if;
    logic convert_strobe;
    logic cs_b;
    logic sck;
    logic din;
    logic sdo_o;
    logic sdo_oe;
    logic sdo;
    logic busy_or_second_data_out;
    logic power_down_input;
    logic reset_pin;
    // Undriven line reads low in the bench
    assign sdo = sdo_oe ? sdo_o : 1'b0;
    modport dev (
        input convert_strobe, cs_b, sck, din, power_down_input, reset_pin,
        output sdo_o, sdo_oe, busy_or_second_data_out
    );
    modport host (
        output convert_strobe, cs_b, sck, din, power_down_input, reset_pin,
        input sdo, busy_or_second_data_out
    );
endinterface
`default_nettype wire

// [rtl/acv_buf2.sv]
`timescale 1ns/100ps
`default_nettype none
module acv_buf2 #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem_r [2];
    logic [W-1:0] mem_nxt [2];
    logic wp_r, wp_nxt, rp_r, rp_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready = (cnt_r != 2'd2);
    assign out_valid = (cnt_r != 2'd0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        mem_nxt = mem_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wp_r] = in_data;
            wp_nxt = ~wp_r;
        end
        if (pop) begin
            rp_nxt = ~rp_r;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 2'd1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 2'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'd0;
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            mem_r <= mem_nxt;
        end
    end
endmodule
`default_nettype wire

// [rtl/acv_dev.sv]
// Contract
// - Power-down sleeps, ignores strobe, silences serial
// - Sleep turns off regulators and reference
// - Host pulses reset after power-down exit
// - Host rewrites config, runs one dummy conversion
// - Host waits 100 ms for reference
// - Config bit 1 picks warp or normal
// - Host bounds interval between warp conversions (host only flags a late warp start on interval_late)
// - Normal default, unbounded, slightly longer busy
// - Chip select may be tied to strobe
// - Conversion covers all enabled channels
// - Strobe rising edge holds, starts internal conversion
// - Strobe ignored until conversion ends
// - Busy high converting; fall marks end
// - Unread result overwritten at next end
// - Incomplete config write discarded at end
// - Config shifted in first 16 clocks, latched
// - New config applies after two conversions
// - Result readable right after end
// - Host keeps quiet near sampling instant
// - Reset loads config all ones
// - Reset or power-down rise aborts, floats output
`timescale 1ns/100ps
`default_nettype none
module acv_dev
    import acv_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    acv_link_if.dev link,
    input wire logic [15:0] sample_word,
    output logic [2:0] sample_ch,
    output logic regulators_on,
    output logic reference_on,
    output logic [15:0] cfg_active
);
    typedef enum logic [1:0] {ST_SLEEP, ST_IDLE, ST_CONV} acv_dstate_t;

    // Order: cnv, cs_b, sck, din, pd, reset
    localparam int NS = 6;
    logic [NS-1:0] pins, s1_r, s2_r, s3_r;
    logic cnv_rise, cs_b_s, sck_rise, sck_fall, din_s, pd_s, pd_rise, rst_s, rst_rise;

    assign pins = {link.reset_pin, link.power_down_input, link.din, link.sck, link.cs_b,
                   link.convert_strobe};
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    assign cnv_rise = s2_r[0] && !s3_r[0];
    assign cs_b_s = s2_r[1];
    assign sck_rise = s2_r[2] && !s3_r[2];
    assign sck_fall = !s2_r[2] && s3_r[2];
    assign din_s = s2_r[3];
    assign pd_s = s2_r[4];
    assign pd_rise = s2_r[4] && !s3_r[4];
    assign rst_s = s2_r[5];
    assign rst_rise = s2_r[5] && !s3_r[5];

    acv_dstate_t st_r, st_nxt;
    logic [15:0] cfg_act_r, cfg_act_nxt, cfg_stage_r, cfg_stage_nxt;
    logic [15:0] res_r [MAX_CH];
    logic [15:0] res_nxt [MAX_CH];
    logic [15:0] acc_r [MAX_CH];
    logic [15:0] acc_nxt [MAX_CH];
    logic [2:0] ch_r, ch_nxt, nch_m1;
    logic [7:0] tcnt_r, tcnt_nxt;
    logic [15:0] out_sh_r, out_sh_nxt, in_sh_r, in_sh_nxt;
    logic [3:0] obit_r, obit_nxt;
    logic [3:0] widx_r, widx_nxt;
    logic [4:0] icnt_r, icnt_nxt;
    logic float_r, float_nxt;
    logic [7:0] tconv;

    assign nch_m1 = {cfg_act_r[CFG_CH_LSB +: CFG_CH_W], 1'b1};
    // Normal slot is the longer one
    assign tconv = cfg_act_r[CFG_CMS_BIT] ? 8'(TCONV_NORM_CYC) : 8'(TCONV_WARP_CYC);

    function automatic logic [15:0] word_at(input logic [3:0] idx, input logic [2:0] last,
                                            input logic [15:0] cfg, input logic [15:0] w);
        if (idx <= {1'b0, last}) begin
            word_at = w;
        end else if (idx == {1'b0, last} + 4'd1) begin
            word_at = cfg;
        end else begin
            word_at = 16'h0000;
        end
    endfunction

    always_comb begin
        st_nxt = st_r;
        cfg_act_nxt = cfg_act_r;
        cfg_stage_nxt = cfg_stage_r;
        res_nxt = res_r;
        acc_nxt = acc_r;
        ch_nxt = ch_r;
        tcnt_nxt = tcnt_r;
        out_sh_nxt = out_sh_r;
        in_sh_nxt = in_sh_r;
        obit_nxt = obit_r;
        widx_nxt = widx_r;
        icnt_nxt = icnt_r;
        float_nxt = float_r;
        case (st_r)
            ST_IDLE: begin
                if (cnv_rise) begin
                    st_nxt = ST_CONV;
                    ch_nxt = 3'd0;
                    tcnt_nxt = tconv;
                end
                if (!cs_b_s && sck_rise && icnt_r < 5'd16) begin
                    in_sh_nxt = {in_sh_r[14:0], din_s};
                    icnt_nxt = icnt_r + 5'd1;
                end
                if (!cs_b_s && sck_fall) begin
                    obit_nxt = obit_r + 4'd1;
                    if (obit_r == 4'd15) begin
                        widx_nxt = widx_r + 4'd1;
                        out_sh_nxt = word_at(widx_r + 4'd1, nch_m1, cfg_act_r,
                                             res_r[3'(widx_r + 4'd1)]);
                    end else begin
                        out_sh_nxt = {out_sh_r[14:0], 1'b0};
                    end
                end
            end
            ST_CONV: begin
                // Strobe edges not looked at here
                if (tcnt_r == 8'd1) begin
                    acc_nxt[ch_r] = sample_word;
                    tcnt_nxt = tconv;
                    ch_nxt = ch_r + 3'd1;
                    if (ch_r == nch_m1) begin
                        st_nxt = ST_IDLE;
                        for (int i = 0; i < MAX_CH; i++) begin
                            res_nxt[i] = (i == int'(ch_r)) ? sample_word : acc_r[i];
                        end
                        cfg_act_nxt = cfg_stage_r;
                        if (icnt_r == 5'd16 && in_sh_r[CFG_UPD_BIT]) begin
                            cfg_stage_nxt = in_sh_r;
                        end
                        icnt_nxt = 5'd0;
                        obit_nxt = 4'd0;
                        widx_nxt = 4'd0;
                        float_nxt = 1'b0;
                        out_sh_nxt = (ch_r == 3'd0) ? sample_word : acc_r[0];
                    end
                end else begin
                    tcnt_nxt = tcnt_r - 8'd1;
                end
            end
            default: begin
                if (!pd_s) begin
                    st_nxt = ST_IDLE;
                end
            end
        endcase
        // Abort and float on rising edge
        if (rst_rise || pd_rise) begin
            float_nxt = 1'b1;
            if (st_r == ST_CONV) begin
                st_nxt = ST_IDLE;
            end
        end
        if (pd_s) begin
            st_nxt = ST_SLEEP;
        end
        if (rst_s) begin
            cfg_act_nxt = CFG_DEFAULT;
            cfg_stage_nxt = CFG_DEFAULT;
            for (int i = 0; i < MAX_CH; i++) begin
                res_nxt[i] = 16'h0000;
            end
            icnt_nxt = 5'd0;
            if (!pd_s) begin
                st_nxt = ST_IDLE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r <= ST_IDLE;
            cfg_act_r <= CFG_DEFAULT;
            cfg_stage_r <= CFG_DEFAULT;
            for (int i = 0; i < MAX_CH; i++) begin
                res_r[i] <= 16'h0000;
                acc_r[i] <= 16'h0000;
            end
            ch_r <= 3'd0;
            tcnt_r <= 8'd0;
            out_sh_r <= 16'h0000;
            in_sh_r <= 16'h0000;
            obit_r <= 4'd0;
            widx_r <= 4'd0;
            icnt_r <= 5'd0;
            float_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            cfg_act_r <= cfg_act_nxt;
            cfg_stage_r <= cfg_stage_nxt;
            res_r <= res_nxt;
            acc_r <= acc_nxt;
            ch_r <= ch_nxt;
            tcnt_r <= tcnt_nxt;
            out_sh_r <= out_sh_nxt;
            in_sh_r <= in_sh_nxt;
            obit_r <= obit_nxt;
            widx_r <= widx_nxt;
            icnt_r <= icnt_nxt;
            float_r <= float_nxt;
        end
    end

    assign link.busy_or_second_data_out = (st_r == ST_CONV);
    assign link.sdo_o = out_sh_r[15];
    // Chip select, idle and the float flag gate output
    assign link.sdo_oe = !cs_b_s && (st_r == ST_IDLE) && !float_r;
    assign regulators_on = (st_r != ST_SLEEP);
    assign reference_on = (st_r != ST_SLEEP) && cfg_act_r[CFG_REF_BIT];
    assign sample_ch = ch_r;
    assign cfg_active = cfg_act_r;
endmodule
`default_nettype wire

// [verif/acv_link_props.sv]
`timescale 1ns/100ps
`default_nettype none
module acv_link_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic convert_strobe,
    input wire logic sck,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    input wire logic busy_or_second_data_out,
    input wire logic power_down_input,
    input wire logic reset_pin
);
    logic busy;
    logic [9:0] len_r, len_nxt;
    logic abort_r, abort_nxt;
    assign busy = busy_or_second_data_out;
    // Aborted conversions end early, so they are kept out of the length check
    always_comb begin
        len_nxt = busy ? len_r + 10'h001 : 10'h000;
        abort_nxt = abort_r;
        if (power_down_input || reset_pin) begin
            abort_nxt = 1'b1;
        end else if (!busy && len_r == 10'h000) begin
            abort_nxt = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            len_r <= 10'h000;
            abort_r <= 1'b0;
        end else begin
            len_r <= len_nxt;
            abort_r <= abort_nxt;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sleep_no_conv_a: assert property (power_down_input && $past(power_down_input, 4) |-> !$rose(busy))
        else $error("conversion started while asleep");
    sleep_quiet_a: assert property (power_down_input && $past(power_down_input, 4) |-> !sdo_oe)
        else $error("serial output driven while asleep");
    strobe_starts_a: assert property ($rose(convert_strobe) && !busy && !power_down_input && !reset_pin
        |-> ##[2:5] busy)
        else $error("strobe rise did not start a conversion");
    busy_length_a: assert property ($fell(busy) && !abort_r
        |-> (len_r % 10'h050 == 10'h000 && len_r <= 10'h140) || (len_r % 10'h064 == 10'h000 && len_r <= 10'h190))
        else $error("busy length is not channels times slot");
    no_retrigger_a: assert property ($fell(busy) |-> !busy [*3])
        else $error("conversion restarted at end of conversion");
    busy_gates_sdo_a: assert property (busy |-> !sdo_oe)
        else $error("serial output driven during conversion");
    abort_floats_a: assert property ($rose(reset_pin) || $rose(power_down_input) |-> ##5 (!sdo_oe && !busy))
        else $error("abort did not stop conversion and float output");
    sdo_on_low_a: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo_o) |-> !sck)
        else $error("serial output changed while clock high");
endmodule
`default_nettype wire

// [verif/adc_conversion_config_pipeline_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_config_pipeline_tb
    import acv_pkg::*;
;
    logic clk = 1'b0, rst_b = 1'b0, start = 1'b0, warp_mode = 1'b0, sleep_req = 1'b0, out_ready = 1'b0;
    logic [3:0] n_words = 4'h1;
    logic [15:0] cfg_word = 16'hFFFF;
    logic [15:0] sample_word, cfg_active, out_data;
    logic [15:0] bcnt = 16'h0000, last_busy = 16'h0000;
    logic [2:0] sample_ch;
    logic regulators_on, reference_on, ready, interval_late, out_valid;
    int failures = 0, n_tests = 0, cyc = 0;
    acv_link_if link ();
    // Each channel returns a word that names it
    assign sample_word = {13'h0B40, sample_ch};
    acv_dev i_acv_dev (.clk(clk), .rst_b(rst_b), .link(link), .sample_word(sample_word), .sample_ch(sample_ch),
        .regulators_on(regulators_on), .reference_on(reference_on), .cfg_active(cfg_active));
    acv_host #(.SETTLE_CYC(20), .WARP_LIMIT(1000)) i_acv_host (.clk(clk), .rst_b(rst_b), .link(link),
        .start(start), .n_words(n_words), .cfg_word(cfg_word), .warp_mode(warp_mode), .sleep_req(sleep_req),
        .ready(ready), .interval_late(interval_late), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data));
    acv_link_props i_acv_link_props (.clk(clk), .rst_b(rst_b), .convert_strobe(link.convert_strobe),
        .sck(link.sck), .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe),
        .busy_or_second_data_out(link.busy_or_second_data_out),
        .power_down_input(link.power_down_input), .reset_pin(link.reset_pin));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (link.busy_or_second_data_out === 1'b1) begin
            bcnt <= bcnt + 16'h0001;
        end else if (bcnt != 16'h0000) begin
            last_busy <= bcnt;
            bcnt <= 16'h0000;
        end
        if (cyc == 40000) begin
            failures++;
            results();
        end
    end
    task automatic results;
        $display("Comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 5000) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 5000) failures++;
    endtask
    task automatic pulse_start;
        wait_ready();
        start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
    endtask
    // Stall holds out_ready low for the first stall loop cycles; a stall of 400 ends before the first word arrives
    task automatic xfer(input logic [15:0] cfg, input int nch, input logic [15:0] cfg_exp, input int busy_cyc,
            input int stall);
        logic [15:0] got [0:9];
        logic hs;
        logic [15:0] d;
        int k;
        int n;
        k = 0;
        n = 0;
        cfg_word = cfg;
        n_words = 4'(nch + 1);
        pulse_start();
        while (k <= nch && n < 8000) begin
            out_ready = (n >= stall);
            @(negedge clk);
            hs = (out_valid === 1'b1) && out_ready;
            d = out_data;
            @(posedge clk);
            if (hs) got[k++] = d;
            #1 n++;
        end
        for (int i = 0; i < nch; i++) check(got[i], 16'(16'h5A00 + i));
        check(got[nch], cfg_exp);
        check(last_busy, 16'(busy_cyc));
        $display("transfer test done, channels %0d", nch);
    endtask
    task automatic sleep_test;
        int seen;
        seen = 0;
        sleep_req = 1'b1;
        repeat (50) @(posedge clk);
        #1;
        check({14'h0000, regulators_on, reference_on}, 16'h0000);
        sleep_req = 1'b0;
        repeat (60) @(posedge clk);
        #1;
        wait_ready();
        check(cfg_active, 16'hFFFF);
        // First conversion after waking is a dummy and must not reach the stream
        n_words = 4'h9;
        out_ready = 1'b1;
        pulse_start();
        repeat (2500) begin
            @(negedge clk);
            if (out_valid === 1'b1) seen++;
        end
        @(posedge clk);
        #1;
        check(16'(seen), 16'h0000);
        $display("sleep test done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        @(posedge clk);
        #1;
        check(cfg_active, 16'hFFFF);
        check({14'h0000, regulators_on, reference_on}, 16'h0003);
        $display("reset test done");
        xfer(16'h9FFF, 8, 16'hFFFF, 8 * TCONV_NORM_CYC, 400);
        xfer(16'h9FFD, 8, 16'hFFFF, 8 * TCONV_NORM_CYC, 0);
        // Default still runs this conversion; readback already shows the staged word
        xfer(16'h9FFD, 2, 16'h9FFF, 8 * TCONV_NORM_CYC, 0);
        warp_mode = 1'b1;
        xfer(16'h9FFD, 2, 16'h9FFD, 2 * TCONV_NORM_CYC, 0);
        check({15'h0000, interval_late}, 16'h0000);
        repeat (1200) @(posedge clk);
        #1;
        xfer(16'h9FFD, 2, 16'h9FFD, 2 * TCONV_WARP_CYC, 0);
        check({15'h0000, interval_late}, 16'h0001);
        warp_mode = 1'b0;
        sleep_test();
        xfer(16'h9FFF, 8, 16'hFFFF, 8 * TCONV_NORM_CYC, 0);
        results();
    end
endmodule
`default_nettype wire
